// ### tb/fdx_chk.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checker
// ----------------------------------------
module fdx_chk #(
  parameter int LINKS = 29
) (
  // clock, reset, bus
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hsel,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  // line side and interrupts
  input wire fdx_pkg::fdx_bcast_end_type bcast_end,
  input wire fdx_pkg::fdx_gc_type        gc_req,
  input wire logic                       exchange_event,
  input wire logic                       clock_value,
  input wire logic                       broadcast_output_irq,
  input wire logic                       global_control_irq,
  input wire logic                       output_data_irq,
  input wire logic                       clock_sync_irq
);
  import fdx_pkg::*;
  logic rq;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign rq = hsel && hready && htrans == FDX_HTRANS_NONSEQ;
  chk_read_wait_state: assert property (rq && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  chk_write_no_wait: assert property (rq && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_gc_irq_follows: assert property (
    gc_req.valid |=> global_control_irq) else $error("gc irq missing");
  chk_gc_irq_cause: assert property (
    global_control_irq |-> $past(gc_req.valid))
    else $error("gc irq without request");
  chk_bo_irq_cause: assert property (
    broadcast_output_irq |-> $past(bcast_end.valid && bcast_end.ok))
    else $error("broadcast irq without good frame");
  chk_bo_bad_silent: assert property (
    bcast_end.valid && !bcast_end.ok |=> !broadcast_output_irq)
    else $error("broadcast irq after bad frame");
  chk_cs_irq_cause: assert property (
    clock_sync_irq |-> $past(clock_value))
    else $error("clock sync irq without clock value");
  chk_od_irq_cause: assert property (
    output_data_irq |-> $past(exchange_event) || $past(gc_req.valid)
    || $past(gc_req.valid, 2)) else $error("output irq without cause");
  cover property (broadcast_output_irq);
  cover property (gc_req.valid ##1 global_control_irq);
  cover property (output_data_irq);
  cover property (clock_sync_irq);
endmodule

bind fdx_top fdx_chk #(.LINKS(LINKS)) u_fdx_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .bcast_end(bcast_end), .gc_req(gc_req),
  .exchange_event(exchange_event), .clock_value(clock_value),
  .broadcast_output_irq(broadcast_output_irq),
  .global_control_irq(global_control_irq),
  .output_data_irq(output_data_irq), .clock_sync_irq(clock_sync_irq)
);

// ### tb/fdx_line_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// line side: master and publishers
// ----------------------------------------
module fdx_line_model (
  // clock
  input  wire logic                   hclk,
  // telegram events
  output fdx_pkg::fdx_bcast_byte_type bcast_byte,
  output fdx_pkg::fdx_bcast_end_type  bcast_end,
  output fdx_pkg::fdx_gc_type         gc_req,
  output logic [2:0]                  ev
);
  import fdx_pkg::*;
  initial begin
    bcast_byte = '0;
    bcast_end = '0;
    gc_req = '0;
    ev = '0;
  end
  task automatic frame(input logic [4:0] lk, input logic ok,
                       input logic [7:0] pub, input int gap);
    logic [7:0] ix [5] = '{8'h00, 8'h01, 8'h02, 8'h03, FDX_SAMPLE_LAST};
    for (int i = 0; i < 5; i++) begin
      bcast_byte <= '{1'b1, ix[i], (i == 1) ? 8'h02 : pub ^ ix[i]};
      @(posedge hclk);
      if (gap > 0) begin
        bcast_byte <= '{1'b0, ~ix[i], ~pub};
        repeat (gap) @(posedge hclk);
      end
    end
    // released lines show the inverse so stale data never looks valid
    bcast_byte <= '{1'b0, ~ix[4], ~pub};
    bcast_end <= '{1'b1, ok, lk};
    @(posedge hclk);
    bcast_end <= '{1'b0, ~ok, ~lk};
    @(posedge hclk);
  endtask
  task automatic gc(input logic [7:0] c, input logic [7:0] g);
    gc_req <= '{1'b1, c, g};
    @(posedge hclk);
    gc_req <= '{1'b0, ~c, ~g};
    @(posedge hclk);
  endtask
  task automatic pulse(input int k);
    ev <= 3'h1 << k;
    @(posedge hclk);
    ev <= 3'h0;
    @(posedge hclk);
  endtask
endmodule

// ### tb/tb_fieldbus_dxb_isosync_clocksync.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); \
  end \
end
module tb_fieldbus_dxb_isosync_clocksync;
  import fdx_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic [13:0]        haddr = '0;
  logic [1:0]         htrans = '0;
  logic               hwrite = 1'b0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        hwdata = '0;
  logic               dx_state = 1'b0;
  logic               masked = 1'b0;
  logic               ack = 1'b0;
  logic               hreadyout, hresp, bo_irq, gc_irq, od_irq, cs_irq, pin;
  logic [31:0]        hrdata, d;
  logic [2:0]         ev;
  fdx_bcast_byte_type bcast_byte;
  fdx_bcast_end_type  bcast_end;
  fdx_gc_type         gc_req;
  logic [7:0]         bo_n = '0, gc_n = '0, od_n = '0, cs_n = '0;
  logic [7:0]         ix [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hf6};
  int                 fail_count = 0, samples_checked = 0, cyc = 0;

  fdx_top #(.LINKS(FDX_MAX_LINKS)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .bcast_byte(bcast_byte), .bcast_end(bcast_end),
    .gc_req(gc_req), .exchange_event(ev[0]),
    .data_exchange_state(dx_state), .time_event(ev[1]),
    .clock_value(ev[2]), .output_data_irq_masked(masked),
    .output_data_irq_ack(ack), .broadcast_output_irq(bo_irq),
    .global_control_irq(gc_irq), .output_data_irq(od_irq),
    .clock_sync_irq(cs_irq), .sync_output_pin(pin)
  );
  fdx_line_model LINE (
    .hclk(hclk), .bcast_byte(bcast_byte), .bcast_end(bcast_end),
    .gc_req(gc_req), .ev(ev)
  );

  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    bo_n <= bo_n + 8'(bo_irq);
    gc_n <= gc_n + 8'(gc_irq);
    od_n <= od_n + 8'(od_irq);
    cs_n <= cs_n + 8'(cs_irq);
    cyc <= cyc + 1;
    // hang guard, well above the ~2650 cycles the run needs
    if (cyc == 10000) begin
      fail_count++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // bus and helpers
  // ----------------------------------------
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= FDX_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {a, 2'b00};
    // values read just after the edge are those the edge sampled
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, '0);
    `CHK(nm, e, d)
  endtask
  task automatic give_ack();
    ack <= 1'b1;
    @(posedge hclk);
    ack <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  task automatic wrap_up();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset view
  task automatic t_reset();
    rchk("state", FDX_IDX_BUF_STATE, 8'hb1);
    rchk("swap", FDX_IDX_BUF_SWAP, 8'h03);
    rchk("type", FDX_IDX_STATUS_TYPE, FDX_STATUS_TYPE);
    rchk("link", FDX_IDX_LINK_BASE, 8'h00);
    rchk("unmapped", 12'h001, 32'h0);
    bus(1'b1, FDX_IDX_BUF_STATE, 32'hff);
    rchk("ro state", FDX_IDX_BUF_STATE, 8'hb1);
    bus(1'b1, FDX_IDX_CONTROL_MATCH, 32'h08);
    bus(1'b1, FDX_IDX_GROUP_MATCH, 32'h80);
    rchk("ctl match", FDX_IDX_CONTROL_MATCH, 8'h08);
  endtask
  task automatic t_frames();
    logic [7:0] b;
    b = bo_n;
    LINE.frame(5'h03, 1'b1, 8'h21, 0);
    repeat (2) @(posedge hclk);
    `CHK("bo irq", b + 8'h1, bo_n)
    rchk("state", FDX_IDX_BUF_STATE, 8'h36);
    rchk("link3", FDX_IDX_LINK_BASE + 12'h3, 8'h01);
    for (int i = 0; i < 5; i++) begin
      rchk("byte", FDX_IDX_MEM_BASE + 12'(ix[i]),
           (i == 1) ? 8'h02 : 8'h21 ^ ix[i]);
    end
    rchk("swap", FDX_IDX_BUF_SWAP, 8'h05);
    rchk("state", FDX_IDX_BUF_STATE, 8'hd2);
    rchk("swap", FDX_IDX_BUF_SWAP, 8'h01);
    rchk("kept", FDX_IDX_MEM_BASE, 8'h21);
    LINE.frame(5'h04, 1'b0, 8'h30, 3);
    repeat (2) @(posedge hclk);
    `CHK("bo irq", b + 8'h1, bo_n)
    rchk("state", FDX_IDX_BUF_STATE, 8'hd2);
    rchk("link4", FDX_IDX_LINK_BASE + 12'h4, 8'h40);
    LINE.frame(5'h05, 1'b1, 8'h41, 0);
    rchk("state", FDX_IDX_BUF_STATE, 8'h1b);
    LINE.frame(5'h06, 1'b1, 8'h51, 0);
    rchk("state", FDX_IDX_BUF_STATE, 8'h1e);
    rchk("byte", FDX_IDX_MEM_BASE + 12'h100, 8'h41);
  endtask
  task automatic t_watchdog();
    bus(1'b1, FDX_IDX_WD_INTERVAL, 32'h2);
    dx_state <= 1'b1;
    repeat (300) @(posedge hclk);
    rchk("link3", FDX_IDX_LINK_BASE + 12'h3, 8'h80);
    rchk("link4", FDX_IDX_LINK_BASE + 12'h4, 8'h00);
    dx_state <= 1'b0;
    repeat (600) @(posedge hclk);
    rchk("link3", FDX_IDX_LINK_BASE + 12'h3, 8'h80);
  endtask
  task automatic t_iso();
    logic       pl [3] = '{1'b0, 1'b1, 1'b1};
    logic [7:0] pw [3] = '{8'h0c, 8'h18, 8'h18};
    int         ln [3] = '{125, 250, 0};
    int         n;
    logic [7:0] b;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, FDX_IDX_SYNC_MODE, {30'h0, pl[i], 1'b1});
      bus(1'b1, FDX_IDX_SYNC_PULSE_WIDTH, 32'(pw[i]));
      b = gc_n;
      LINE.gc(8'h08, 8'h80 ^ 8'(i == 2));
      n = 0;
      repeat (300) begin
        @(negedge hclk);
        n += int'(pin === pl[i]);
      end
      `CHK("width", ln[i], n)
      `CHK("gc irq", b + 8'h1, gc_n)
    end
  endtask
  task automatic t_simple();
    logic [7:0] o;
    bus(1'b1, FDX_IDX_SYNC_MODE, 32'h4);
    o = od_n;
    LINE.gc(8'h08, 8'h80);
    repeat (5) @(posedge hclk);
    `CHK("od idle", o, od_n)
    `CHK("pin idle", 1'b1, pin)
    LINE.pulse(0);
    repeat (5) @(posedge hclk);
    `CHK("od held", o, od_n)
    LINE.gc(8'h08, 8'h80);
    repeat (20) @(posedge hclk);
    `CHK("od sync", o + 8'h1, od_n)
    `CHK("pin on", 1'b0, pin)
    give_ack();
    `CHK("pin off", 1'b1, pin)
    LINE.gc(8'h08, 8'h80);
    repeat (5) @(posedge hclk);
    `CHK("od once", o + 8'h1, od_n)
    masked <= 1'b1;
    LINE.pulse(0);
    LINE.gc(8'h08, 8'h80);
    repeat (5) @(posedge hclk);
    `CHK("od masked", o + 8'h2, od_n)
    `CHK("pin masked", 1'b1, pin)
    give_ack();
    masked <= 1'b0;
    bus(1'b1, FDX_IDX_SYNC_MODE, 32'h0);
    LINE.pulse(0);
    repeat (3) @(posedge hclk);
    `CHK("od direct", o + 8'h3, od_n)
  endtask
  task automatic t_clock();
    logic [7:0]  b;
    logic [31:0] t;
    b = cs_n;
    LINE.pulse(1);
    repeat (300) @(posedge hclk);
    `CHK("cs quiet", b, cs_n)
    LINE.pulse(2);
    repeat (2) @(posedge hclk);
    `CHK("cs irq", b + 8'h1, cs_n)
    bus(1'b0, FDX_IDX_RX_DELAY, '0);
    t = d;
    `CHK("delay range", 1'b1, t >= 32'h2 && t <= 32'h3)
    repeat (300) @(posedge hclk);
    rchk("delay held", FDX_IDX_RX_DELAY, t);
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_frames();
    t_watchdog();
    t_iso();
    t_simple();
    t_clock();
    wrap_up();
  end
endmodule

// ### verilog/fdx_pkg.sv
package fdx_pkg;

  // ------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [11:0] FDX_IDX_CONTROL_MATCH = 12'h00e;
  localparam logic [11:0] FDX_IDX_GROUP_MATCH   = 12'h00f;
  localparam logic [11:0] FDX_IDX_BUF_STATE     = 12'h012;
  localparam logic [11:0] FDX_IDX_BUF_SWAP      = 12'h013;
  localparam logic [11:0] FDX_IDX_SYNC_MODE     = 12'h014;
  localparam logic [11:0] FDX_IDX_SYNC_PULSE_WIDTH       = 12'h015;
  localparam logic [11:0] FDX_IDX_WD_INTERVAL   = 12'h016;
  localparam logic [11:0] FDX_IDX_RX_DELAY      = 12'h017;
  localparam logic [11:0] FDX_IDX_STATUS_TYPE   = 12'h018;
  localparam logic [11:0] FDX_IDX_LINK_BASE     = 12'h020;
  localparam logic [11:0] FDX_IDX_MEM_BASE      = 12'h400;

  // ------------------------------------------------------------------
  // field layouts and constants
  // ------------------------------------------------------------------
  localparam int          FDX_MODE_SYNC_EN   = 0;
  localparam int          FDX_MODE_SYNC_POL  = 1;
  localparam int          FDX_MODE_DX_PORT   = 2;
  localparam int          FDX_LINK_ACTIVE    = 7;
  localparam int          FDX_LINK_ERROR     = 6;
  localparam int          FDX_LINK_DATA      = 0;
  localparam logic [7:0]  FDX_STATUS_TYPE    = 8'h83;
  localparam logic [7:0]  FDX_SAMPLE_LAST    = 8'hf6;
  localparam logic [1:0]  FDX_PTR_NIL        = 2'h0;
  localparam logic [1:0]  FDX_PTR_ONE        = 2'h1;
  localparam logic [1:0]  FDX_PTR_TWO        = 2'h2;
  localparam logic [1:0]  FDX_PTR_THREE      = 2'h3;
  localparam logic [1:0]  FDX_HTRANS_NONSEQ  = 2'h2;
  localparam int          FDX_MAX_LINKS      = 29;

  // ------------------------------------------------------------------
  // timing: clock rate and the 1/12 us pulse-width base
  // ------------------------------------------------------------------
  localparam int          FDX_CLK_MHZ        = 125;
  localparam int          FDX_PW_TICKS_PER_US = 12;
  localparam logic [6:0]  FDX_US_CYCLES      = 7'(FDX_CLK_MHZ);
  localparam logic [6:0]  FDX_PW_STEP        = 7'(FDX_PW_TICKS_PER_US);

  // ------------------------------------------------------------------
  // carriers from the line-side receiver
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] index;
    logic [7:0] data;
  } fdx_bcast_byte_type;

  typedef struct packed {
    logic       valid;
    logic       ok;
    logic [4:0] link;
  } fdx_bcast_end_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] control;
    logic [7:0] group;
  } fdx_gc_type;

endpackage

// ### verilog/fdx_top.sv
`timescale 1ns/100ps
// Functional notes
// - rotate broadcast buffers, never clear them
// - received bytes go to D buffer
// - good frame: D moves to N, irq
// - swap read moves N to U
// - state register packs F,U,N,D pointers
// - swap register: flag bit2, pointer bits1-0
// - frame end updates that publisher's link
// - watchdog interval evaluates all links, restarts
// - link flags follow the update table
// - link byte layout, defaults zero, type 0x83
// - SYNCH needs control and group match
// - isochronous: SYNCH gives pulse and irq
// - simple sync defers data-output irq
// - sync polarity bit, width times 1/12us
// - simple sync signal follows masked irq
// - time event starts delay timer
// - at most 29 publisher links
module fdx_top #(
  parameter int LINKS = fdx_pkg::FDX_MAX_LINKS
) (
  // clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [13:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic [31:0]                      hrdata,
  output logic                             hresp,
  // line-side receiver
  input  wire fdx_pkg::fdx_bcast_byte_type bcast_byte,
  input  wire fdx_pkg::fdx_bcast_end_type  bcast_end,
  input  wire fdx_pkg::fdx_gc_type         gc_req,
  input  wire logic                        exchange_event,
  input  wire logic                        data_exchange_state,
  input  wire logic                        time_event,
  input  wire logic                        clock_value,
  // interrupt controller side
  input  wire logic                        output_data_irq_masked,
  input  wire logic                        output_data_irq_ack,
  output logic                             broadcast_output_irq,
  output logic                             global_control_irq,
  output logic                             output_data_irq,
  output logic                             clock_sync_irq,
  // pin
  output logic                             sync_output_pin
);
  import fdx_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic              rd_pend;
    logic              wr_pend;
    logic [11:0]       idx;
    logic [31:0]       rdata;
    logic              ready;
    logic [7:0]        ctrl_match;
    logic [7:0]        group_match;
    logic [2:0]        mode;
    logic [7:0]        pw;
    logic [15:0]       wd_interval;
    logic [1:0]        f;
    logic [1:0]        u;
    logic [1:0]        n;
    logic [1:0]        d;
    logic [LINKS-1:0]  active;
    logic [LINKS-1:0]  err;
    logic [LINKS-1:0]  de;
    logic [6:0]        us_cnt;
    logic [15:0]       wd_cnt;
    logic [6:0]        acc;
    logic [7:0]        pw_cnt;
    logic              pulse;
    logic              dx_pending;
    logic              dx_latch;
    logic [31:0]       rd_timer;
    logic              rd_running;
    logic              te_seen;
    logic              sync_out;
    logic              bc_irq;
    logic              gc_irq;
    logic              od_irq;
    logic              cs_irq;
  } fdx_state_type;

  fdx_state_type state_reg;
  fdx_state_type state_next;

  logic [7:0]  mem [0:767];
  logic [7:0]  mem_rd;
  logic [9:0]  mem_off;
  logic [11:0] rel;
  logic        us_tick;
  logic        pw_tick;
  logic        simple_mode;
  logic        synch;
  logic        swapped;
  logic [7:0]  link_byte;
  logic [4:0]  li;
  logic [7:0]  acc_sum;

  // ------------------------------------------------------------------
  // sample memory
  // ------------------------------------------------------------------
  // no clearing
  // the buffers are only ever overwritten by new frames, never wiped,
  // so a slow reader still sees the last sample set
  // write into D
  always_ff @(posedge hclk) begin
    if (bcast_byte.valid && bcast_byte.index <= FDX_SAMPLE_LAST &&
        state_reg.d != FDX_PTR_NIL) begin
      mem[{state_reg.d - FDX_PTR_ONE, bcast_byte.index}] <=
        bcast_byte.data;
    end
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.bc_irq = 1'b0;
    state_next.gc_irq = 1'b0;
    state_next.od_irq = 1'b0;
    state_next.cs_irq = 1'b0;
    rel = state_reg.idx - FDX_IDX_MEM_BASE;
    mem_off = rel[9:0];
    // only three 256-byte pages exist; anything above reads as zero
    // rather than aliasing back onto a buffer
    mem_rd = 8'h00;
    if (rel[11:10] == 2'h0 && rel[9:8] != 2'h3) begin
      mem_rd = mem[mem_off];
    end
    li = 5'(state_reg.idx - FDX_IDX_LINK_BASE);
    link_byte = 8'h00;
    swapped = 1'b0;
    simple_mode = state_reg.mode[FDX_MODE_DX_PORT] &
                  ~state_reg.mode[FDX_MODE_SYNC_EN];

    // time bases
    // both ticks free-run; a pulse start re-aligns the fine one
    us_tick = (state_reg.us_cnt == FDX_US_CYCLES - 7'h01);
    state_next.us_cnt = us_tick ? 7'h00 : state_reg.us_cnt + 7'h01;
    // the sum needs one bit more than the accumulator, since it can
    // reach 136 before the wrap at the microsecond count
    acc_sum = {1'b0, state_reg.acc} + {1'b0, FDX_PW_STEP};
    pw_tick = (acc_sum >= {1'b0, FDX_US_CYCLES});
    state_next.acc = pw_tick ? 7'(acc_sum - {1'b0, FDX_US_CYCLES})
                             : acc_sum[6:0];

    // bus address phase; reads take one wait state so that a write
    // just ahead of them has already landed
    state_next.rd_pend = 1'b0;
    state_next.wr_pend = 1'b0;
    state_next.ready = 1'b1;
    if (hsel && hready && htrans == FDX_HTRANS_NONSEQ) begin
      state_next.idx = haddr[13:2];
      state_next.wr_pend = hwrite;
      state_next.rd_pend = ~hwrite;
      state_next.ready = hwrite;
    end

    // bus write data phase
    if (state_reg.wr_pend) begin
      if (state_reg.idx == FDX_IDX_CONTROL_MATCH) begin
        state_next.ctrl_match = hwdata[7:0];
      end else if (state_reg.idx == FDX_IDX_GROUP_MATCH) begin
        state_next.group_match = hwdata[7:0];
      end else if (state_reg.idx == FDX_IDX_SYNC_MODE) begin
        state_next.mode = hwdata[2:0];
      end else if (state_reg.idx == FDX_IDX_SYNC_PULSE_WIDTH) begin
        state_next.pw = hwdata[7:0];
      end else if (state_reg.idx == FDX_IDX_WD_INTERVAL) begin
        state_next.wd_interval = hwdata[15:0];
      end
    end

    // bus read data phase
    state_next.rdata = 32'h0000_0000;
    if (state_reg.rd_pend) begin
      if (state_reg.idx == FDX_IDX_CONTROL_MATCH) begin
        state_next.rdata[7:0] = state_reg.ctrl_match;
      end else if (state_reg.idx == FDX_IDX_GROUP_MATCH) begin
        state_next.rdata[7:0] = state_reg.group_match;
      end else if (state_reg.idx == FDX_IDX_BUF_STATE) begin
        state_next.rdata[7:0] = {state_reg.f, state_reg.u,
                                 state_reg.n, state_reg.d};
      end else if (state_reg.idx == FDX_IDX_BUF_SWAP) begin
        // N to U
        // the swap fires on the edge that loads hrdata, once per read
        if (state_reg.n != FDX_PTR_NIL) begin
          swapped = 1'b1;
          state_next.u = state_reg.n;
          state_next.f = state_reg.u;
          state_next.n = FDX_PTR_NIL;
        end
        state_next.rdata[7:0] = {5'h00, swapped, state_next.u};
      end else if (state_reg.idx == FDX_IDX_SYNC_MODE) begin
        state_next.rdata[2:0] = state_reg.mode;
      end else if (state_reg.idx == FDX_IDX_SYNC_PULSE_WIDTH) begin
        state_next.rdata[7:0] = state_reg.pw;
      end else if (state_reg.idx == FDX_IDX_WD_INTERVAL) begin
        state_next.rdata[15:0] = state_reg.wd_interval;
      end else if (state_reg.idx == FDX_IDX_RX_DELAY) begin
        state_next.rdata = state_reg.rd_timer;
        state_next.rd_running = 1'b0;
      end else if (state_reg.idx == FDX_IDX_STATUS_TYPE) begin
        state_next.rdata[7:0] = FDX_STATUS_TYPE;
      end else if (state_reg.idx >= FDX_IDX_LINK_BASE &&
                   state_reg.idx < FDX_IDX_LINK_BASE + 12'(LINKS)) begin
        link_byte[FDX_LINK_ACTIVE] = state_reg.active[li];
        link_byte[FDX_LINK_ERROR] = state_reg.err[li];
        link_byte[FDX_LINK_DATA] = state_reg.de[li];
        state_next.rdata[7:0] = link_byte;
      end else if (state_reg.idx >= FDX_IDX_MEM_BASE) begin
        state_next.rdata[7:0] = mem_rd;
      end
    end

    // interval expiry
    // a zero interval keeps monitoring off, like a disabled watchdog
    if (!data_exchange_state || state_reg.wd_interval == 16'h0000) begin
      state_next.wd_cnt = 16'h0000;
    end else if (us_tick) begin
      if (state_reg.wd_cnt >= state_reg.wd_interval - 16'h0001) begin
        state_next.wd_cnt = 16'h0000;
        state_next.active = state_reg.de;
        state_next.err = '0;
        state_next.de = '0;
      end else begin
        state_next.wd_cnt = state_reg.wd_cnt + 16'h0001;
      end
    end

    // frame end comes after expiry so a receipt is never lost
    if (bcast_end.valid) begin
      if (32'(bcast_end.link) < LINKS) begin
        if (bcast_end.ok) begin
          state_next.err[bcast_end.link] = 1'b0;
          state_next.de[bcast_end.link] = 1'b1;
        end else begin
          state_next.active[bcast_end.link] = 1'b0;
          state_next.err[bcast_end.link] = 1'b1;
          state_next.de[bcast_end.link] = 1'b0;
        end
      end
      if (bcast_end.ok && state_next.d != FDX_PTR_NIL) begin
        state_next.n = state_next.d;
        if (state_next.n != FDX_PTR_NIL && state_reg.n != FDX_PTR_NIL &&
            !swapped) begin
          state_next.d = state_reg.n;
        end else begin
          state_next.d = state_next.f;
          state_next.f = FDX_PTR_NIL;
        end
        state_next.bc_irq = 1'b1;
      end
    end

    synch = gc_req.valid && gc_req.control == state_reg.ctrl_match &&
            gc_req.group == state_reg.group_match;
    state_next.gc_irq = gc_req.valid;

    if (synch && state_reg.mode[FDX_MODE_SYNC_EN] &&
        state_reg.pw != 8'h00) begin
      state_next.pulse = 1'b1;
      state_next.pw_cnt = state_reg.pw;
      state_next.acc = 7'h00;
    end else if (state_reg.pulse && pw_tick) begin
      state_next.pw_cnt = state_reg.pw_cnt - 8'h01;
      state_next.pulse = (state_reg.pw_cnt != 8'h01);
    end

    if (simple_mode) begin
      if (synch && state_reg.dx_pending) begin
        state_next.od_irq = 1'b1;
        state_next.dx_latch = 1'b1;
        state_next.dx_pending = 1'b0;
      end
      if (exchange_event) begin
        state_next.dx_pending = 1'b1;
      end
    end else begin
      state_next.od_irq = exchange_event;
      state_next.dx_pending = 1'b0;
    end
    if (output_data_irq_ack && !state_next.od_irq) begin
      state_next.dx_latch = 1'b0;
    end

    state_next.sync_out = ~(state_reg.pulse |
                            (simple_mode & state_reg.dx_latch &
                             ~output_data_irq_masked)) ^
                          state_reg.mode[FDX_MODE_SYNC_POL];

    if (us_tick && state_reg.rd_running) begin
      state_next.rd_timer = state_reg.rd_timer + 32'h0000_0001;
    end
    if (clock_value && state_reg.te_seen) begin
      state_next.cs_irq = 1'b1;
      state_next.te_seen = 1'b0;
    end
    if (time_event) begin
      state_next.rd_timer = 32'h0000_0000;
      state_next.rd_running = 1'b1;
      state_next.te_seen = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
      state_reg.ready <= 1'b1;
      state_reg.f <= FDX_PTR_TWO;
      state_reg.u <= FDX_PTR_THREE;
      state_reg.n <= FDX_PTR_NIL;
      state_reg.d <= FDX_PTR_ONE;
      state_reg.sync_out <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hreadyout = state_reg.ready;
  assign hrdata = state_reg.rdata;
  assign hresp = 1'b0;
  assign broadcast_output_irq = state_reg.bc_irq;
  assign global_control_irq = state_reg.gc_irq;
  assign output_data_irq = state_reg.od_irq;
  assign clock_sync_irq = state_reg.cs_irq;
  assign sync_output_pin = state_reg.sync_out;

endmodule
